// File: bench/pdio_lines.sv
// Far side: external lines that drive wherever the port does not
module pdio_lines (
   input  wire [15:0] port_lines_o,
   input  wire [15:0] port_lines_oe_n,
   input  wire [15:0] ext,
   output wire [15:0] port_lines_i
);
   timeunit 1ns;
   timeprecision 1ns;
   assign port_lines_i = (port_lines_o & ~port_lines_oe_n) | (ext & port_lines_oe_n);
endmodule

// File: bench/pdio_port_monitor.sv
// Concurrent checks on the digital port pins and host replies
module pdio_monitor (
   input wire        clk, rst, host_wr, host_rd, host_word, host_rvalid,
   input wire        low_group_direction, high_group_direction,
   input wire [1:0]  host_sel,
   input wire [15:0] host_wdata, host_rdata, port_lines_i, port_lines_o, port_lines_oe_n
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   property p_rv; host_rd |=> host_rvalid; endproperty
   a_rv: assert property (p_rv) else $error("rvalid");
   property p_dir; host_wr && host_sel == 2 ##1 !host_wr |=>
      {high_group_direction, low_group_direction} == $past(host_wdata[1:0], 2); endproperty
   a_dir: assert property (p_dir) else $error("dir");
   property p_oe; $rose(low_group_direction) |-> ##[0:2] !port_lines_oe_n[0]; endproperty
   a_oe: assert property (p_oe) else $error("oe");
   property p_lo; host_wr && host_sel == 0 |->
      ##2 port_lines_o[7:0] == $past(host_wdata[7:0], 2); endproperty
   a_lo: assert property (p_lo) else $error("low");
   property p_hi; host_wr && host_sel == 1 |->
      ##2 port_lines_o[15:8] == $past(host_wdata[7:0], 2); endproperty
   a_hi: assert property (p_hi) else $error("high");
   property p_wd; host_wr && host_sel == 0 && host_word |->
      ##2 port_lines_o[15:8] == $past(host_wdata[15:8], 2); endproperty
   a_wd: assert property (p_wd) else $error("word");
   property p_rd; host_rd && host_word && host_sel == 0 && $stable(port_lines_i) &&
      port_lines_i == $past(port_lines_i, 2) |=> host_rdata == $past(port_lines_i); endproperty
   a_rd: assert property (p_rd) else $error("read");
   property p_rst; $fell(rst) |-> (port_lines_o & port_lines_oe_n) == 16'hffff; endproperty
   a_rst: assert property (p_rst) else $error("reset");
endmodule
bind pdio_port pdio_monitor mon (.*);

// File: bench/tb.sv
// Self-checking bench for the parallel digital port
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 0, rst = 1, host_wr = 0, host_rd = 0, host_word = 0, host_rvalid;
   logic        low_group_direction, high_group_direction;
   logic [1:0]  host_sel = 0;
   logic [15:0] host_wdata = 0, host_rdata, port_lines_i, port_lines_o, port_lines_oe_n;
   logic [15:0] ext = 0, ex, oe, v;
   logic [31:0] seed = 32'h6fc5_7383;
   integer      failures = 0, num_checks = 0, mo = 16'hffff, d, i, k;
   always #10 clk = ~clk;
   pdio_port dut (.*);
   pdio_lines far (.*);
   function logic [31:0] rnd;
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   task chk(input [16:0] s, e, input string n);
      num_checks++;
      if (s !== e) begin
         failures++;
         $display("[ERR] %s exp %h seen %h", n, e, s);
      end
   endtask
   task op(input [1:0] s, input w, r, b, input [15:0] x);
      @(posedge clk);
      {host_sel, host_wr, host_rd, host_word, host_wdata} <= {s, w, r, b, x};
      @(posedge clk);
      {host_wr, host_rd} <= 2'h0;
   endtask
   task rd(input [1:0] s, input b, input [15:0] e);
      op(s, 0, 1, b, 16'h0000);
      // Reply stands only in the cycle after the read edge
      #1;
      chk({host_rvalid, host_rdata}, {1'b1, e}, "read");
   endtask
   task stop_test;
      if (failures == 0 && num_checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge clk);
      rst <= 0;
      for (d = 0; d < 4; d++) begin
         op(2, 1, 0, 0, d[15:0]);
         oe = {{8{!d[1]}}, {8{!d[0]}}};
         rd(2, 0, {14'h0000, d[1:0]});
         for (i = 0; i < 8; i++) begin
            @(posedge clk) ext <= 16'(rnd());
            repeat (4) @(posedge clk);
            #1;
            ex = {d[1] ? mo[15:8] : ext[15:8], d[0] ? mo[7:0] : ext[7:0]};
            chk({1'b0, port_lines_oe_n}, {1'b0, oe}, "oe_n");
            chk({1'b0, port_lines_o | oe}, {1'b0, mo[15:0] | oe}, "lines");
            rd(0, 1, ex);
            rd(1, 0, {8'h00, ex[15:8]});
            k = rnd() % 3;
            v = 16'(rnd());
            op(k == 1, 1, 0, k == 2, v);
            mo = k == 2 ? v : k == 1 ? {v[7:0], mo[7:0]} : {mo[15:8], v[7:0]};
         end
      end
      @(posedge clk) rst <= 1;
      @(posedge clk) rst <= 0;
      #1;
      chk({1'b0, port_lines_o & port_lines_oe_n}, {1'b0, 16'hffff}, "reset");
      rd(3, 1, 16'h0000);
      stop_test;
   end
endmodule

// File: src/pdio_defs.vh
// Constants for the sixteen-line parallel digital port
`ifndef PDIO_DEFS_VH
`define PDIO_DEFS_VH

// ****************************************
// Register selects (host port address)
// ****************************************
`define PDIO_SEL_W        2
`define PDIO_SEL_LOW      2'h0
`define PDIO_SEL_HIGH     2'h1
`define PDIO_SEL_DIR      2'h2

// ****************************************
// Field layout and reset values
// ****************************************
`define PDIO_LINES        16
`define PDIO_GRP_W        8
`define PDIO_LO_MSB       7
`define PDIO_HI_LSB       8
`define PDIO_HI_MSB       15
`define PDIO_DIR_LO_BIT   0
`define PDIO_DIR_HI_BIT   1
`define PDIO_OUT_RST      8'hff
`define PDIO_DIR_RST      1'b0
`define PDIO_ZERO8        8'h00
`define PDIO_GROUPS       2
`define PDIO_DIR_PAD      6'h00

`endif

// File: src/pdio_group.v
// One eight-line group: output latch, direction and pin drive
`include "pdio_defs.vh"

module pdio_group (
   // Clock and reset
   input  wire                      clk,
   input  wire                      rst,
   // Host side
   input  wire                      wr_en,
   input  wire [`PDIO_GRP_W-1:0]    wr_data,
   input  wire                      dir_wr,
   input  wire                      dir_bit,
   output reg                       dir_reg,
   output reg  [`PDIO_GRP_W-1:0]    in_reg,
   // Pins
   input  wire [`PDIO_GRP_W-1:0]    pin_i,
   output reg  [`PDIO_GRP_W-1:0]    pin_o,
   output reg  [`PDIO_GRP_W-1:0]    pin_oe_n
);

   reg [`PDIO_GRP_W-1:0] out_reg;

   always @(posedge clk or posedge rst) begin
      if (rst) begin
         out_reg  <= `PDIO_OUT_RST;
         dir_reg  <= `PDIO_DIR_RST;
         pin_o    <= `PDIO_OUT_RST;
         pin_oe_n <= `PDIO_OUT_RST;
         in_reg   <= `PDIO_ZERO8;
      end else begin
         if (wr_en) begin
            out_reg <= wr_data;
         end
         if (dir_wr) begin
            dir_reg <= dir_bit;
         end
         // latch kept while input, no inversion
         pin_o    <= wr_en ? wr_data : out_reg;
         pin_oe_n <= (dir_wr ? dir_bit : dir_reg) ? `PDIO_ZERO8 : `PDIO_OUT_RST;
         // sample the line level, driven or not
         in_reg   <= pin_i;
      end
   end

endmodule

// File: src/pdio_port.v
// Sixteen-line bidirectional parallel digital port, host byte/word access
// Operation
// - Sixteen lines set as inputs or outputs in two groups of eight.
// - Direction bit one makes a group drive; zero makes it input.
// - Reads return present line levels, including lines being driven.
// - Written output bits set line levels one clock after the write edge, through two register stages.
// - Data mapping is non-inverting: one is high, zero is low.
// - Either input byte may be read alone at any time.
// - Word read at low address returns low byte low, high byte high.
// - Either output byte may be written alone, touching only its group.
// - Word write at low address updates both groups, lower byte low.
// - Outputs go inactive high at power-up and system reset.
`include "pdio_defs.vh"

module pdio_port (
   // Clock and reset
   input  wire                      clk,
   input  wire                      rst,
   // Host command port
   input  wire [`PDIO_SEL_W-1:0]    host_sel,
   input  wire                      host_wr,
   input  wire                      host_rd,
   input  wire                      host_word,
   input  wire [`PDIO_LINES-1:0]    host_wdata,
   output reg  [`PDIO_LINES-1:0]    host_rdata,
   output reg                       host_rvalid,
   // Direction status
   output reg                       low_group_direction,
   output reg                       high_group_direction,
   // Port lines
   input  wire [`PDIO_LINES-1:0]    port_lines_i,
   output reg  [`PDIO_LINES-1:0]    port_lines_o,
   output reg  [`PDIO_LINES-1:0]    port_lines_oe_n
);

   wire [1:0]              dir_q;
   wire [`PDIO_LINES-1:0]  in_q;
   wire [`PDIO_LINES-1:0]  pin_o_w;
   wire [`PDIO_LINES-1:0]  pin_oe_w;
   wire [1:0]              grp_wr;
   wire                    dir_wr;

   // Decode which group a data access touches
   function grp_hit;
      input [`PDIO_SEL_W-1:0] sel;
      input                   word;
      input                   grp;
      begin
         if (grp) begin
            grp_hit = (sel == `PDIO_SEL_HIGH) || (word && sel == `PDIO_SEL_LOW);
         end else begin
            grp_hit = (sel == `PDIO_SEL_LOW);
         end
      end
   endfunction

   // ****************************************
   // Groups
   // ****************************************
   // byte or word write routing
   assign grp_wr[0] = host_wr && grp_hit(host_sel, host_word, 1'b0);
   assign grp_wr[1] = host_wr && grp_hit(host_sel, host_word, 1'b1);
   assign dir_wr    = host_wr && (host_sel == `PDIO_SEL_DIR);

   genvar g;
   generate
      for (g = 0; g < `PDIO_GROUPS; g = g + 1) begin : grp
         pdio_group u_grp (
            .clk      (clk),
            .rst      (rst),
            .wr_en    (grp_wr[g]),
            .wr_data  ((g == 0 || host_sel == `PDIO_SEL_HIGH) ?
                       (host_sel == `PDIO_SEL_HIGH ? host_wdata[`PDIO_LO_MSB:0]
                                                   : host_wdata[`PDIO_LO_MSB:0])
                       : host_wdata[`PDIO_HI_MSB:`PDIO_HI_LSB]),
            .dir_wr   (dir_wr),
            .dir_bit  (host_wdata[g]),
            .dir_reg  (dir_q[g]),
            .in_reg   (in_q[g*`PDIO_GRP_W +: `PDIO_GRP_W]),
            .pin_i    (port_lines_i[g*`PDIO_GRP_W +: `PDIO_GRP_W]),
            .pin_o    (pin_o_w[g*`PDIO_GRP_W +: `PDIO_GRP_W]),
            .pin_oe_n (pin_oe_w[g*`PDIO_GRP_W +: `PDIO_GRP_W])
         );
      end
   endgenerate

   // ****************************************
   // Outputs and read port
   // ****************************************
   always @(posedge clk or posedge rst) begin
      if (rst) begin
         host_rdata           <= {`PDIO_ZERO8, `PDIO_ZERO8};
         host_rvalid          <= 1'b0;
         low_group_direction  <= `PDIO_DIR_RST;
         high_group_direction <= `PDIO_DIR_RST;
         port_lines_o         <= {`PDIO_OUT_RST, `PDIO_OUT_RST};
         port_lines_oe_n      <= {`PDIO_OUT_RST, `PDIO_OUT_RST};
      end else begin
         low_group_direction  <= dir_q[`PDIO_DIR_LO_BIT];
         high_group_direction <= dir_q[`PDIO_DIR_HI_BIT];
         port_lines_o         <= pin_o_w;
         port_lines_oe_n      <= pin_oe_w;
         host_rvalid          <= host_rd;
         case (host_sel)
            `PDIO_SEL_LOW: begin
               host_rdata <= host_word ? in_q : {`PDIO_ZERO8, in_q[`PDIO_LO_MSB:0]};
            end
            `PDIO_SEL_HIGH: begin
               host_rdata <= {`PDIO_ZERO8, in_q[`PDIO_HI_MSB:`PDIO_HI_LSB]};
            end
            `PDIO_SEL_DIR: begin
               host_rdata <= {`PDIO_ZERO8, `PDIO_DIR_PAD, dir_q};
            end
            default: begin
               host_rdata <= {`PDIO_ZERO8, `PDIO_ZERO8};
            end
         endcase
      end
   end

endmodule
